// ===== rtl/capture_timer_pair.v
// Two-channel 16-bit capture and auto-reload timer with an AXI4-Lite register slave.
// Behaviour
// - Mode 00 runs auto-reload; any other mode runs capture.
// - Clock select picks sys/12, fast/2^4,5,7,10,14,18 or the event pin.
// - Sys/12 runs except in full stop, from fast or slow oscillator.
// - Binary-divided fast clocks run only in fast-all or fast-peripheral state.
// - Enabled counter increments on falling count-clock edge; disabled counter holds.
// - No match is raised while the enable bit is zero.
// - Auto-reload counts 0 to N-1; a match clears the counter.
// - Each auto-reload match sets the interrupt flag.
// - Flag clears by interrupt acknowledge or software write.
// - Capture edge: 01 rising, 10 falling, 11 either.
// - Capture mode wraps modulo 65536; only clear bit resets it.
// - Capture overflow 65535 to 0 sets the interrupt flag.
// - Selected capture-pin edge while counting copies count into data latch.
// - Data latch stays software-writable in capture mode.
// - Writing one to clear bit zeroes the counter; zero does nothing.
// - Clock select 111 counts the channel's own event pin edges.
// - Counter is read-only, resets to zero, changes by count, clear or match.
`timescale 1ns/1ns
`include "capture_timer_map.vh"

module capture_timer_pair (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire [2:0]  power_state,
  input  wire        slow_tick,
  input  wire        ch1_event_pin,
  input  wire        ch2_event_pin,
  input  wire        ch1_capture_pin,
  input  wire        ch2_capture_pin,
  input  wire        ch1_irq_ack,
  input  wire        ch2_irq_ack,
  output wire        ch1_irq_flag,
  output wire        ch2_irq_flag,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ==================================================================
  // Decoding helpers

  // Returns {hit, channel, field index} for a byte address.
  function [5:0] decode;
    input [11:0] addr;
    reg          page_ok;
    reg          fld_ok;
    begin
      page_ok = (addr[9:6] == `IDX_CH1_PAGE) || (addr[9:6] == `IDX_CH2_PAGE);
      fld_ok  = (addr[5:2] >= `IDX_CTRL) && (addr[5:2] <= `IDX_FLAG);
      decode  = {page_ok & fld_ok & (addr[11:10] == 2'b00) & (addr[1:0] == 2'b00),
                 addr[6] ^ 1'b1, addr[5:2]};
    end
  endfunction

  // One-cycle falling edge of prescaler stage sel (binary divider by 2^k).
  function div_tick;
    input [2:0]             sel;
    input [`PRESCALE_W-1:0] pre;
    input                   run;
    begin
      case (sel)
        3'b001:  div_tick = run & (&pre[3:0]);
        3'b010:  div_tick = run & (&pre[4:0]);
        3'b011:  div_tick = run & (&pre[6:0]);
        3'b100:  div_tick = run & (&pre[9:0]);
        3'b101:  div_tick = run & (&pre[13:0]);
        3'b110:  div_tick = run & (&pre[17:0]);
        default: div_tick = 1'b0;
      endcase
    end
  endfunction

  // ==================================================================
  // Reset release

  reg        rst_meta_b_r;
  reg        rst_sync_b_r;

  // The reset asserts at once but releases on mclk so no flop sees a runt release.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end

  // ==================================================================
  // Shared clock sources

  reg  [`PRESCALE_W-1:0] pre_r;
  reg  [3:0]             div12_r;
  wire                   fast_run;
  wire                   slow_run;
  wire                   base12;
  wire                   tick12;

  // fast gating: binary dividers stop outside the fast states.
  assign fast_run = (power_state == `PWR_FAST_ALL) || (power_state == `PWR_FAST_PERI);
  assign slow_run = (power_state == `PWR_SLOW_ALL) || (power_state == `PWR_SLOW_PERI);
  // sys source: fast oscillator in fast states, slow ticks in slow states, none in full stop.
  assign base12   = fast_run | (slow_run & slow_tick);
  assign tick12   = base12 & (div12_r == `SYS_DIV_LAST);

  // Prescaler runs only in the fast states; the divide-by-12 counter advances on each sys source tick.
  always @(posedge mclk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      pre_r   <= {`PRESCALE_W{1'b0}};
      div12_r <= 4'd0;
    end else begin
      if (fast_run)
        pre_r <= pre_r + 1'b1;
      if (base12)
        div12_r <= tick12 ? 4'd0 : div12_r + 4'd1;
    end
  end

  // ==================================================================
  // Bus slave

  reg        awready_r;
  reg        wready_r;
  reg        bvalid_r;
  reg  [1:0] bresp_r;
  reg        aw_got_r;
  reg        w_got_r;
  reg [11:0] awaddr_r;
  reg  [7:0] wbyte_r;
  reg        wlane_r;
  reg        arready_r;
  reg        rvalid_r;
  reg [31:0] rdata_r;
  reg  [1:0] rresp_r;
  wire       do_wr;
  wire [5:0] wdec;
  wire [5:0] rdec;
  wire [15:0] ctrl_v;
  wire [31:0] cnt_v;
  wire [31:0] dat_v;
  wire [1:0]  flag_v;
  reg  [7:0]  rbyte;

  assign do_wr = aw_got_r & w_got_r;
  assign wdec  = decode(awaddr_r);
  assign rdec  = decode(s_axi_araddr);

  // Read data mux over the per-channel views.
  always @* begin
    case (rdec[3:0])
      `IDX_CTRL:      rbyte = ctrl_v[rdec[4]*8 +: 8];
      `IDX_CNT_LOW:   rbyte = cnt_v[rdec[4]*16 +: 8];
      `IDX_CNT_HIGH:  rbyte = cnt_v[rdec[4]*16+8 +: 8];
      `IDX_DATA_LOW:  rbyte = dat_v[rdec[4]*16 +: 8];
      `IDX_DATA_HIGH: rbyte = dat_v[rdec[4]*16+8 +: 8];
      `IDX_FLAG:      rbyte = {7'd0, flag_v[rdec[4]]};
      default:        rbyte = 8'h00;
    endcase
  end

  // Address and data are caught in either order; the write lands once both are held.
  always @(posedge mclk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 12'h000;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
    end else begin
      if (s_axi_awvalid & awready_r) begin
        awready_r <= 1'b0;
        aw_got_r  <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (!aw_got_r & !bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid & wready_r) begin
        wready_r <= 1'b0;
        w_got_r  <= 1'b1;
        wbyte_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end else if (!w_got_r & !bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wdec[5] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge mclk or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else if (s_axi_arvalid & arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, rdec[5] ? rbyte : 8'h00};
      rresp_r   <= rdec[5] ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==================================================================
  // Timer channels

  wire [1:0] ev_pin;
  wire [1:0] cap_pin;
  wire [1:0] ack_in;

  assign ev_pin  = {ch2_event_pin, ch1_event_pin};
  assign cap_pin = {ch2_capture_pin, ch1_capture_pin};
  assign ack_in  = {ch2_irq_ack, ch1_irq_ack};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      reg  [7:0]  ctrl_r;
      reg  [15:0] cnt_r;
      reg  [15:0] dat_r;
      reg         flag_r;
      reg  [2:0]  ev_sync_r;
      reg  [2:0]  cap_sync_r;
      wire        hit;
      wire        wr_ctrl;
      wire        wr_flag;
      wire        enable;
      wire        reload;
      wire        ev_fall;
      wire        cap_rise;
      wire        cap_fall;
      wire        cap_hit;
      wire        src_tick;
      wire        step;
      wire        match;
      wire        ovf;
      wire        clr_req;
      wire [15:0] cnt_inc;

      assign hit     = do_wr & wlane_r & wdec[5] & (wdec[4] == ch);
      assign wr_ctrl = hit & (wdec[3:0] == `IDX_CTRL);
      assign wr_flag = hit & (wdec[3:0] == `IDX_FLAG) & wbyte_r[0];
      assign enable  = ctrl_r[`CTRL_EN_BIT];
      // mode choice: only code 00 selects auto-reload.
      assign reload  = (ctrl_r[`CTRL_MD_HI:`CTRL_MD_LO] == `MODE_RELOAD);
      // edge detect: only the second and third stages feed logic.
      assign ev_fall  = ev_sync_r[2] & ~ev_sync_r[1];
      assign cap_rise = ~cap_sync_r[2] & cap_sync_r[1];
      assign cap_fall = cap_sync_r[2] & ~cap_sync_r[1];
      // edge select: 01 rising, 10 falling, 11 either.
      assign cap_hit  = (ctrl_r[`CTRL_MD_LO] & cap_rise) | (ctrl_r[`CTRL_MD_HI] & cap_fall);
      // clock mux; event pin counting on code 111.
      assign src_tick = (ctrl_r[`CTRL_FS_HI:`CTRL_FS_LO] == `FS_SYS12) ? tick12 :
                        (ctrl_r[`CTRL_FS_HI:`CTRL_FS_LO] == `FS_EVENT) ? ev_fall :
                        div_tick(ctrl_r[`CTRL_FS_HI:`CTRL_FS_LO], pre_r, fast_run);
      // gating: a disabled channel sees no count edges.
      assign step    = enable & src_tick;
      assign cnt_inc = cnt_r + 16'h0001;
      // match: enabled reload only, when the next count reaches N.
      assign match   = step & reload & (cnt_inc == dat_r);
      assign ovf     = step & ~reload & (cnt_r == 16'hFFFF);
      // clear strobe: only a written one acts.
      assign clr_req = wr_ctrl & wbyte_r[`CTRL_CLR_BIT];

      // Two stages catch each pin; the third only holds the last value for edge detection.
      always @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
          ev_sync_r  <= 3'b000;
          cap_sync_r <= 3'b000;
        end else begin
          ev_sync_r  <= {ev_sync_r[1:0], ev_pin[ch]};
          cap_sync_r <= {cap_sync_r[1:0], cap_pin[ch]};
        end
      end

      // Control, counter, data latch and flag of one channel.
      always @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
          // reset value of the control register.
          ctrl_r <= `CTRL_RESET;
          cnt_r  <= 16'h0000;
          dat_r  <= 16'h0000;
          flag_r <= 1'b0;
        end else begin
          // clear bit not stored; reserved bit not stored.
          if (wr_ctrl)
            ctrl_r <= wbyte_r & `CTRL_KEEP_MASK;
          // counter changes only by clear, match or count.
          if (clr_req)
            cnt_r <= 16'h0000;
          else if (match)
            cnt_r <= 16'h0000;
          else if (step)
            cnt_r <= cnt_inc;
          // capture while counting wins over a same-cycle software write.
          if (~reload & enable & cap_hit)
            dat_r <= cnt_r;
          // data bytes writable in every mode.
          else if (hit & (wdec[3:0] == `IDX_DATA_LOW))
            dat_r[7:0] <= wbyte_r;
          else if (hit & (wdec[3:0] == `IDX_DATA_HIGH))
            dat_r[15:8] <= wbyte_r;
          // set the flag; set wins over a clear.
          if (match | ovf)
            flag_r <= 1'b1;
          else if (ack_in[ch] | wr_flag)
            flag_r <= 1'b0;
        end
      end

      assign ctrl_v[ch*8 +: 8]   = ctrl_r;
      assign cnt_v[ch*16 +: 16]  = cnt_r;
      assign dat_v[ch*16 +: 16]  = dat_r;
      assign flag_v[ch]          = flag_r;
    end
  endgenerate

  assign ch1_irq_flag = flag_v[0];
  assign ch2_irq_flag = flag_v[1];

endmodule

// ===== rtl/capture_timer_map.vh
// Register indices, field positions, reset values and timing counts of the capture timer pair.
`ifndef CAPTURE_TIMER_MAP_VH
`define CAPTURE_TIMER_MAP_VH
// ==================================================================
// Register indices (byte address is four times the index)
`define IDX_CH1_CTRL    8'hD1
`define IDX_CH2_CTRL    8'hE1
`define IDX_CNT_LOW     4'h2
`define IDX_CNT_HIGH    4'h3
`define IDX_DATA_LOW    4'h4
`define IDX_DATA_HIGH   4'h5
`define IDX_FLAG        4'h6
`define IDX_CTRL        4'h1
`define IDX_CH1_PAGE    4'hD
`define IDX_CH2_PAGE    4'hE
// ==================================================================
// Control register fields
`define CTRL_EN_BIT     7
`define CTRL_CLR_BIT    6
`define CTRL_FS_HI      5
`define CTRL_FS_LO      3
`define CTRL_RSV_BIT    2
`define CTRL_MD_HI      1
`define CTRL_MD_LO      0
`define CTRL_RESET      8'h00
`define CTRL_KEEP_MASK  8'hBB
// ==================================================================
// Mode and clock select codes
`define MODE_RELOAD     2'b00
`define MODE_CAP_RISE   2'b01
`define MODE_CAP_FALL   2'b10
`define MODE_CAP_ANY    2'b11
`define FS_SYS12        3'b000
`define FS_EVENT        3'b111
// ==================================================================
// Power states
`define PWR_FAST_ALL    3'd0
`define PWR_FAST_PERI   3'd1
`define PWR_SLOW_ALL    3'd2
`define PWR_SLOW_PERI   3'd3
`define PWR_FULL_STOP   3'd4
// ==================================================================
// Timing counts
`define SYS_DIV         12
`define SYS_DIV_LAST    4'd11
`define PRESCALE_W      18
// ==================================================================
// Bus answers
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// ===== bench/timer_sva.sv
// Bus and flag checker for the capture timer pair.
`timescale 1ns/1ns
// ==========
// Checker
module timer_sva (
  input wire        mclk,
  input wire        rst_b,
  input wire        ch1_irq_ack,
  input wire        ch1_irq_flag,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp
);
  // The flag is never asserted on while reset is low, so the first edges are safe.
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read accepted");
  ctrl_readback_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h344
    |=> s_axi_rresp == 2'b00 && s_axi_rdata[6] == 1'b0 && s_axi_rdata[2] == 1'b0) else $error("control bits");
  flag_clear_a: assert property ($fell(ch1_irq_flag) |-> $past(ch1_irq_ack) || $rose(s_axi_bvalid))
    else $error("flag fell without cause");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[1:2] s_axi_arready)
    else $error("read slot not freed");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[1:2] s_axi_awready)
    else $error("write slot not freed");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(ch1_irq_flag));
endmodule
bind capture_timer_pair timer_sva chk (.*);

// ===== bench/pin_source.sv
// Model of the external event and capture pins of both channels.
`timescale 1ns/1ns
module pin_source (
  input wire   mclk,
  output logic ch1_event_pin,
  output logic ch2_event_pin,
  output logic ch1_capture_pin,
  output logic ch2_capture_pin
);
  // Pins idle low.
  initial begin
    {ch1_event_pin, ch2_event_pin, ch1_capture_pin, ch2_capture_pin} = 4'h0;
  end
  // Each high level lasts three cycles and each low one at least three, beyond the two the synchroniser needs.
  task automatic events(input int ch, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (ch == 1) ch1_event_pin <= 1'b1; else ch2_event_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      if (ch == 1) ch1_event_pin <= 1'b0; else ch2_event_pin <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
  endtask
  // Settle time covers synchroniser and edge detector.
  task automatic cap(input int ch, input logic v);
    @(posedge mclk);
    if (ch == 1) ch1_capture_pin <= v; else ch2_capture_pin <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ===== bench/test_capture_timer_pair.sv
// Self-checking testbench of the capture timer pair.
`timescale 1ns/1ns
module test_capture_timer_pair;
  logic        mclk, rst_b, slow_tick, ch1_irq_ack, ch2_irq_ack;
  logic [2:0]  power_state;
  wire         ch1_event_pin, ch2_event_pin, ch1_capture_pin, ch2_capture_pin, ch1_irq_flag, ch2_irq_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          miscompares = 0, tests_run = 0;
  logic [7:0]  rv, c1;
  logic [1:0]  rr, wresp;
  capture_timer_pair dut (.*);
  pin_source pins (.*);
  // ==========
  // Clock and helpers
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address and data go out together; each is dropped at its own handshake.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a; s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && s_axi_awready) begin s_axi_awvalid <= 0; ad = 1; end
      if (!wd && s_axi_wready) begin s_axi_wvalid <= 0; wd = 1; end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a, rv, rr);
    check(rv, e);
  endtask
  task give_verdict;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Scenarios
  task t_reset;
    rc(12'h344, 8'h00);
    wr(12'h344, 8'h44); rc(12'h344, 8'h00);
    wr(12'h348, 8'h55); check(wresp, 2'b00); rc(12'h348, 8'h00);
    rd(12'h000, rv, rr); check(rr, 2'b10);
    wr(12'h000, 8'h11); check(wresp, 2'b10);
    $display("reset test done");
  endtask
  // Modulo three on the event pin; the disabled spell would otherwise reach a match.
  task t_reload;
    wr(12'h350, 8'h03); wr(12'h354, 8'h00); wr(12'h344, 8'hB8);
    pins.events(1, 2); rc(12'h348, 8'h02);
    wr(12'h344, 8'hB8); rc(12'h348, 8'h02);
    pins.events(1, 1); rc(12'h348, 8'h00); check(ch1_irq_flag, 1);
    ch1_irq_ack <= 1; @(posedge mclk); ch1_irq_ack <= 0; @(posedge mclk);
    check(ch1_irq_flag, 0);
    pins.events(1, 2); wr(12'h344, 8'h38); pins.events(1, 5);
    rc(12'h348, 8'h02); check(ch1_irq_flag, 0);
    wr(12'h344, 8'hB8); pins.events(1, 1); check(ch1_irq_flag, 1);
    rc(12'h348, 8'h00);
    wr(12'h358, 8'h01); check(ch1_irq_flag, 0);
    $display("reload test done");
  endtask
  task t_capture;
    logic [2:0] m;
    logic [7:0] e;
    for (m = 1; m <= 3; m++) begin
      // Data 4 lies on the count's path, so a stray compare would clear the counter.
      wr(12'h384, {6'h3E, m[1:0]}); wr(12'h390, 8'h04); wr(12'h394, 8'h00);
      rc(12'h390, 8'h04);
      pins.events(2, 3); pins.cap(2, 1); e = (m == 2) ? 8'h04 : 8'h03;
      rc(12'h390, e);
      pins.events(2, 2); pins.cap(2, 0); if (m != 1) e = 8'h05;
      rc(12'h390, e);
      rc(12'h388, 8'h05);
      check(ch2_irq_flag, 0);
    end
    $display("capture test done");
  endtask
  task t_prescale;
    wr(12'h350, 8'h00); wr(12'h344, 8'hC0); rc(12'h344, 8'h80);
    repeat (240) @(posedge mclk);
    rd(12'h348, rv, rr); check(rv >= 19 && rv <= 22, 1);
    power_state <= 3'd4; rd(12'h348, c1, rr); repeat (240) @(posedge mclk);
    rc(12'h348, c1);
    power_state <= 3'd2; rd(12'h348, c1, rr);
    repeat (24) begin slow_tick <= 1; @(posedge mclk); slow_tick <= 0; @(posedge mclk); end
    rd(12'h348, rv, rr); check(rv - c1, 2);
    wr(12'h344, 8'hC8); repeat (64) @(posedge mclk); rc(12'h348, 8'h00);
    power_state <= 3'd0;
    repeat (64) @(posedge mclk);
    rd(12'h348, rv, rr); check(rv >= 3 && rv <= 5, 1);
    $display("prescale test done");
  endtask
  // ==========
  // Main sequence
  initial begin
    rst_b = 0; power_state = 0; slow_tick = 0; ch1_irq_ack = 0; ch2_irq_ack = 0;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    repeat (3) @(posedge mclk);
    t_reset; t_reload; t_capture; t_prescale;
    give_verdict;
  end
  // The whole run needs well under two thousand cycles, so this limit means a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict;
  end
endmodule
